// ---- shared/tca_pkg.sv ----
/*
 * package for the temperature conversion and limit alarm core:
 * register map, config fields, reset values, sequencer states, timing.
 * assumes a 20 MHz system clock.
 */
package tca_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_CONFIG = 3'h1;
    localparam logic [2:0] ADDR_RESULT = 3'h2;
    localparam logic [2:0] ADDR_ID     = 3'h3;
    localparam logic [2:0] ADDR_CRIT   = 3'h4;
    localparam logic [2:0] ADDR_HYST   = 3'h5;
    localparam logic [2:0] ADDR_HIGH   = 3'h6;
    localparam logic [2:0] ADDR_LOW    = 3'h7;
    // ------------------------------------------------------------
    // config fields
    // ------------------------------------------------------------
    localparam int CFG_RES      = 7;
    localparam int CFG_MODE_HI  = 6;
    localparam int CFG_MODE_LO  = 5;
    localparam int CFG_CMP      = 4;
    localparam int CFG_CRIT_POL = 3;
    localparam int CFG_LIM_POL  = 2;
    localparam int CFG_FQ_HI    = 1;
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_ONE  = 2'h1;
    localparam logic [1:0] MODE_SPS  = 2'h2;
    localparam logic [1:0] MODE_SHUT = 2'h3;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CONFIG = 8'h00;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_CRIT   = 16'h4980;
    localparam logic [7:0]  RST_HYST   = 8'h05;
    localparam logic [15:0] RST_HIGH   = 16'h2000;
    localparam logic [15:0] RST_LOW    = 16'h0500;
    localparam logic [7:0]  ID_CODE    = 8'h5a; // arbitrary value
    localparam int HYST_SHIFT = 7;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ     = 20000;
    localparam int T_CONV_US   = 240000;
    localparam int T_FAST_US   = 6000;
    localparam int T_SPS_US    = 60000;
    localparam int T_IDLE_US   = 940000;
    localparam int T_WAKE_US   = 1000;
    // scale to cycles per microsecond first: keeps products inside int
    localparam int CONV_CYC    = T_CONV_US * (CLK_KHZ / 1000);
    localparam int FAST_CYC    = T_FAST_US * (CLK_KHZ / 1000);
    localparam int SPS_CYC     = T_SPS_US * (CLK_KHZ / 1000);
    localparam int IDLE_CYC    = T_IDLE_US * (CLK_KHZ / 1000);
    localparam int WAKE_CYC    = T_WAKE_US * (CLK_KHZ / 1000);
    localparam int CNT_W       = 25;

    typedef enum logic [1:0] {
        SEQ_OFF  = 2'b00,
        SEQ_CONV = 2'b01,
        SEQ_WAIT = 2'b10,
        SEQ_WAKE = 2'b11
    } tca_seq_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } tca_req_t;
endpackage : tca_pkg

// ---- src/tca_core.sv ----
/*
 * conversion sequencer, result store, limit comparison, fault queue
 * and alarm pin drive of a temperature sensor.
 * assumes register accesses already decoded from the serial port into
 * one-cycle strobes, and a sampled converter code on adc_code.
 */
`timescale 1ns/10ps
module tca_core import tca_pkg::*; #(
    parameter int CONV_N = CONV_CYC,
    parameter int FAST_N = FAST_CYC,
    parameter int SPS_N  = SPS_CYC,
    parameter int IDLE_N = IDLE_CYC,
    parameter int WAKE_N = WAKE_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire tca_req_t    req,
    input  wire logic [15:0] adc_code,
    output logic [15:0]      rdata,
    output logic             critical_alarm_pin_o,
    output logic             critical_alarm_pin_oe,
    output logic             limit_alarm_pin_o,
    output logic             limit_alarm_pin_oe
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic signed [16:0] sx(input logic [15:0] v);
        sx = signed'({v[15], v});
    endfunction : sx

    function automatic logic [2:0] depth(input logic [1:0] q);
        depth = {1'b0, q} + 3'h1;
    endfunction : depth

    tca_seq_t         state;
    logic [CNT_W-1:0] cnt;
    logic [7:0]       cfg;
    logic [15:0]      result;
    logic [15:0]      crit_lim;
    logic [7:0]       hyst;
    logic [15:0]      high_lim;
    logic [15:0]      low_lim;
    logic             rdy_n;
    logic [2:0]       flags;
    logic [2:0]       crit_cnt;
    logic [2:0]       lim_cnt;
    logic             crit_act;
    logic             lim_act;

    logic [1:0]        mode;
    logic              cmp_mode;
    logic              done;
    logic              mode_wr;
    logic [1:0]        wr_mode;
    logic              any_rd;
    logic [15:0]       sample;
    logic signed [16:0] t;
    logic signed [16:0] hy;
    logic              v_crit;
    logic              v_high;
    logic              v_low;
    logic              in_crit;
    logic              in_lim;
    logic              trip_crit;
    logic              trip_lim;

    assign mode     = cfg[CFG_MODE_HI:CFG_MODE_LO];
    assign cmp_mode = cfg[CFG_CMP];
    assign done     = (state == SEQ_CONV) && (cnt == '0);
    assign mode_wr  = req.wr && (req.addr == ADDR_CONFIG);
    assign wr_mode  = req.wdata[CFG_MODE_HI:CFG_MODE_LO];
    assign any_rd   = req.rd;

    // ------------------------------------------------------------
    // result formatting and comparison
    // ------------------------------------------------------------
    // 16-bit step 1/128; 13-bit keeps 15:3, step 1/16
    assign sample = cfg[CFG_RES] ? adc_code
                  : {adc_code[15:3], 3'h0};
    assign t      = sx(sample);
    assign hy     = signed'(17'(hyst) << HYST_SHIFT);
    assign v_crit = t > sx(crit_lim);
    assign v_high = t > sx(high_lim);
    assign v_low  = t < sx(low_lim);
    assign in_crit = sx(result) < sx(crit_lim) - hy;
    assign in_lim  = (sx(result) < sx(high_lim) - hy)
                  && (sx(result) > sx(low_lim) + hy);
    assign trip_crit = done && v_crit
                    && (crit_cnt + 3'h1 >= depth(cfg[CFG_FQ_HI:0]));
    assign trip_lim  = done && (v_high || v_low)
                    && (lim_cnt + 3'h1 >= depth(cfg[CFG_FQ_HI:0]));

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= SEQ_CONV;
            cnt   <= CNT_W'(FAST_N - 1);
        end else if (mode_wr && wr_mode != mode) begin
            case (wr_mode)
                MODE_ONE: begin
                    state <= SEQ_CONV;
                    cnt   <= CNT_W'(CONV_N - 1);
                end
                MODE_SPS: begin
                    state <= SEQ_CONV;
                    cnt   <= CNT_W'(SPS_N - 1);
                end
                MODE_SHUT: begin
                    state <= SEQ_OFF;
                    cnt   <= '0;
                end
                default: begin
                    if (state == SEQ_OFF) begin
                        state <= SEQ_WAKE;
                        cnt   <= CNT_W'(WAKE_N - 1);
                    end
                end
            endcase
        end else if (mode_wr && wr_mode == MODE_ONE) begin
            state <= SEQ_CONV;
            cnt   <= CNT_W'(CONV_N - 1);
        end else if (cnt != '0) begin
            cnt <= cnt - CNT_W'(1);
        end else begin
            case (state)
                SEQ_CONV: begin
                    case (mode)
                        MODE_CONT: begin
                            cnt <= CNT_W'(CONV_N - 1);
                        end
                        MODE_SPS: begin
                            state <= SEQ_WAIT;
                            cnt   <= CNT_W'(IDLE_N - 1);
                        end
                        default: begin
                            state <= SEQ_OFF;
                        end
                    endcase
                end
                SEQ_WAIT: begin
                    state <= SEQ_CONV;
                    cnt   <= CNT_W'(SPS_N - 1);
                end
                SEQ_WAKE: begin
                    state <= SEQ_CONV;
                    cnt   <= CNT_W'(CONV_N - 1);
                end
                default: begin
                    state <= SEQ_OFF;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // result and ready bit
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result <= RST_RESULT;
        end else if (done) begin
            // shutdown keeps the last value
            result <= cfg[CFG_RES] ? sample
                    : {sample[15:3], v_crit, v_high, v_low};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdy_n <= 1'b1;
        end else if (done) begin
            rdy_n <= 1'b0;
        end else if (req.rd && req.addr == ADDR_RESULT) begin
            rdy_n <= 1'b1;
        end else if (mode_wr && mode != MODE_CONT) begin
            rdy_n <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg      <= RST_CONFIG;
            crit_lim <= RST_CRIT;
            hyst     <= RST_HYST;
            high_lim <= RST_HIGH;
            low_lim  <= RST_LOW;
        end else if (req.wr) begin
            case (req.addr)
                ADDR_CONFIG: cfg      <= req.wdata[7:0];
                ADDR_CRIT:   crit_lim <= req.wdata;
                ADDR_HYST:   hyst     <= req.wdata[7:0];
                ADDR_HIGH:   high_lim <= req.wdata;
                ADDR_LOW:    low_lim  <= req.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_STATUS: rdata <= {8'h0, rdy_n, flags, 4'h0};
                ADDR_CONFIG: rdata <= {8'h0, cfg};
                ADDR_RESULT: rdata <= result;
                ADDR_ID:     rdata <= {8'h0, ID_CODE};
                ADDR_CRIT:   rdata <= crit_lim;
                ADDR_HYST:   rdata <= {8'h0, hyst};
                ADDR_HIGH:   rdata <= high_lim;
                default:     rdata <= low_lim;
            endcase
        end
    end

    // ------------------------------------------------------------
    // fault queue
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crit_cnt <= '0;
            lim_cnt  <= '0;
        end else if (done) begin
            crit_cnt <= !v_crit ? 3'h0
                      : (crit_cnt < 3'h4) ? crit_cnt + 3'h1 : crit_cnt;
            lim_cnt  <= !(v_high || v_low) ? 3'h0
                      : (lim_cnt < 3'h4) ? lim_cnt + 3'h1 : lim_cnt;
        end
    end

    // ------------------------------------------------------------
    // status flags: set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags <= '0;
        end else begin
            if (trip_crit) begin
                flags[2] <= 1'b1;
            end else if ((req.rd && req.addr == ADDR_STATUS) || in_crit) begin
                flags[2] <= 1'b0;
            end
            if (trip_lim && v_high) begin
                flags[1] <= 1'b1;
            end else if ((req.rd && req.addr == ADDR_STATUS)
                         || sx(result) < sx(high_lim) - hy) begin
                flags[1] <= 1'b0;
            end
            if (trip_lim && v_low) begin
                flags[0] <= 1'b1;
            end else if ((req.rd && req.addr == ADDR_STATUS)
                         || sx(result) > sx(low_lim) + hy) begin
                flags[0] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // alarm state
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            crit_act <= 1'b0;
        end else if (trip_crit) begin
            crit_act <= 1'b1;
        end else if (!cmp_mode && any_rd) begin
            crit_act <= 1'b0;
        end else if (cmp_mode && in_crit && (!done
                     || (mode_wr && wr_mode == MODE_ONE))) begin
            crit_act <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lim_act <= 1'b0;
        end else if (trip_lim) begin
            lim_act <= 1'b1;
        end else if (!cmp_mode && any_rd) begin
            lim_act <= 1'b0;
        end else if (cmp_mode && in_lim && (!done
                     || (mode_wr && wr_mode == MODE_ONE))) begin
            lim_act <= 1'b0;
        end
    end

    // open drain: pull low when level wanted is low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            critical_alarm_pin_o  <= 1'b0;
            critical_alarm_pin_oe <= 1'b0;
            limit_alarm_pin_o     <= 1'b0;
            limit_alarm_pin_oe    <= 1'b0;
        end else begin
            critical_alarm_pin_o  <= 1'b0;
            limit_alarm_pin_o     <= 1'b0;
            critical_alarm_pin_oe <= crit_act ^ cfg[CFG_CRIT_POL];
            limit_alarm_pin_oe    <= lim_act ^ cfg[CFG_LIM_POL];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_rdy_set: assert property (done |=> !rdy_n)
        else $error("ready bit not low after result");
    a_rdy_clear: assert property (
        !done && req.rd && req.addr == ADDR_RESULT |=> rdy_n)
        else $error("ready bit not back after result read");
    a_result_store: assert property (
        done |=> result[15:3] == $past(adc_code[15:3]))
        else $error("result not stored");
    a_cont_restart: assert property (
        done && mode == MODE_CONT && !req.wr
        |=> state == SEQ_CONV && cnt == CNT_W'(CONV_N - 1))
        else $error("continuous mode did not restart");
    a_oneshot_go: assert property (
        mode_wr && wr_mode == MODE_ONE |=> state == SEQ_CONV)
        else $error("single conversion not started");
    a_shut_enter: assert property (
        mode_wr && wr_mode == MODE_SHUT |=> state == SEQ_OFF)
        else $error("shutdown not entered");
    a_shut_hold: assert property (
        state == SEQ_OFF |=> $stable(result))
        else $error("result changed in shutdown");
    a_sps_idle: assert property (
        done && mode == MODE_SPS && !req.wr |=> state == SEQ_WAIT)
        else $error("no idle after short conversion");
    a_int_release: assert property (
        !cmp_mode && req.rd && !done ##1 !done |=> !lim_act && !crit_act)
        else $error("read did not release alarms");
    a_fault_reset: assert property (
        done && !v_crit |=> crit_cnt == 3'h0)
        else $error("fault count not cleared");

    c_cont: cover property (done ##1 state == SEQ_CONV);
    c_one: cover property (mode_wr && wr_mode == MODE_ONE);
    c_trip: cover property (trip_lim ##1 lim_act);
    c_wake: cover property (state == SEQ_WAKE ##1 state == SEQ_CONV);
endmodule : tca_core

// ---- verif/tca_host.sv ----
/*
 * host model: register port master of the sensor core.
 * assumes the bench calls its tasks from clock-aligned code.
 */
`timescale 1ns/10ps
module tca_host import tca_pkg::*; (
    input  wire logic clk,
    output tca_req_t  req
);
    // ------------------------------------------------------------
    // bus idle
    // ------------------------------------------------------------
    initial req = '0;

    // ------------------------------------------------------------
    // accesses: one 16-bit word each
    // ------------------------------------------------------------
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd   <= 1'b0;
        req.addr <= ~a;
    endtask : rd

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr    <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~d;
    endtask : wr

    // single conversion: rewrite mode 01, then hold off a full conversion
    task automatic one_shot(input logic [7:0] cfg, input int conv_n);
        wr(ADDR_CONFIG, {8'h00, cfg});
        repeat (conv_n + 6) @(posedge clk);
    endtask : one_shot
endmodule : tca_host

// ---- verif/tca_bench.sv ----
/*
 * self-checking bench for the conversion and alarm core.
 * assumes tca_host as register master and pull-ups on both alarm pins.
 */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module temperature_conversion_and_limit_alarms_bench import tca_pkg::*;;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int CONV = 20;
    localparam int WAKE = 5;
    logic        clk;
    logic        nrst;
    logic [15:0] adc_code;
    logic [15:0] rdata;
    tca_req_t    req;
    logic        crit_o;
    logic        crit_oe;
    logic        lim_o;
    logic        lim_oe;
    logic        rd_seen;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [15:0] lfsr;
    int          mismatches;
    int          comparisons;
    wire logic   crit_lvl = crit_oe ? crit_o : 1'b1;
    wire logic   lim_lvl  = lim_oe ? lim_o : 1'b1;

    tca_core #(.CONV_N(CONV), .FAST_N(10), .SPS_N(10), .IDLE_N(30), .WAKE_N(WAKE)) i_tca_core (
        .clk                   (clk),
        .nrst                  (nrst),
        .req                   (req),
        .adc_code              (adc_code),
        .rdata                 (rdata),
        .critical_alarm_pin_o  (crit_o),
        .critical_alarm_pin_oe (crit_oe),
        .limit_alarm_pin_o     (lim_o),
        .limit_alarm_pin_oe    (lim_oe)
    );
    tca_host i_tca_host (
        .clk (clk),
        .req (req)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [15:0] next_lfsr(input logic [15:0] l);
        return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
    endfunction : next_lfsr

    task automatic rd(input logic [2:0] a, input logic [15:0] x);
        exp_q.push_back(x);
        i_tca_host.rd(a);
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic set_adc(input logic [15:0] v);
        @(posedge clk);
        adc_code <= v;
    endtask : set_adc

    task automatic pins(input logic ec, input logic el);
        #1;
        `CHK("critical pin", ec, crit_lvl)
        `CHK("limit pin", el, lim_lvl)
    endtask : pins

    task automatic done(input string nm);
        $display("test %s finished", nm);
    endtask : done

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // read data watcher
    // ------------------------------------------------------------
    always @(posedge clk) rd_seen <= req.rd;
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("Error rdata expected nothing seen %h", rdata);
            end else begin
                e = exp_q.pop_front();
                `CHK("rdata", e, rdata)
            end
        end
    end

    initial begin
        cyc(20000);
        mismatches++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        nrst        = 1'b0;
        adc_code    = 16'h0c80;
        lfsr        = 16'h004f;
        mismatches  = 0;
        comparisons = 0;
        cyc(2);
        nrst <= 1'b1;
        rd(ADDR_STATUS, 16'h0080);
        rd(ADDR_CONFIG, 16'h0000);
        rd(ADDR_CRIT, 16'h4980);
        rd(ADDR_HYST, 16'h0005);
        rd(ADDR_HIGH, 16'h2000);
        rd(ADDR_LOW, 16'h0500);
        i_tca_host.wr(ADDR_RESULT, 16'hffff);
        i_tca_host.wr(ADDR_CONFIG, 16'h0060);
        rd(ADDR_RESULT, 16'h0c80);
        done("reset");
        i_tca_host.one_shot(8'h20, CONV);
        rd(ADDR_STATUS, 16'h0000);
        rd(ADDR_RESULT, 16'h0c80);
        rd(ADDR_STATUS, 16'h0080);
        set_adc(16'h1000);
        cyc(CONV + 6);
        rd(ADDR_RESULT, 16'h0c80);
        pins(1'b1, 1'b1);
        done("one shot");
        for (int i = 0; i < 3; i++) begin
            lfsr = next_lfsr(lfsr);
            set_adc(16'h0800 + {5'h00, lfsr[10:0]});
            i_tca_host.one_shot(8'ha0, CONV);
            rd(ADDR_RESULT, 16'h0800 + {5'h00, lfsr[10:0]});
        end
        done("wide format");
        set_adc(16'h2300);
        i_tca_host.one_shot(8'h21, CONV);
        pins(1'b1, 1'b1);
        i_tca_host.one_shot(8'h21, CONV);
        pins(1'b1, 1'b0);
        rd(ADDR_RESULT, 16'h2302);
        cyc(3);
        pins(1'b1, 1'b1);
        done("fault queue");
        i_tca_host.one_shot(8'h30, CONV);
        pins(1'b1, 1'b0);
        rd(ADDR_RESULT, 16'h2302);
        cyc(3);
        pins(1'b1, 1'b0);
        set_adc(16'h0c80);
        i_tca_host.one_shot(8'h30, CONV);
        pins(1'b1, 1'b1);
        done("comparator");
        set_adc(16'h4b00);
        i_tca_host.one_shot(8'h20, CONV);
        pins(1'b0, 1'b0);
        rd(ADDR_RESULT, 16'h4b06);
        cyc(3);
        pins(1'b1, 1'b1);
        done("critical");
        i_tca_host.wr(ADDR_CONFIG, 16'h006c);
        cyc(3);
        pins(1'b0, 1'b0);
        done("polarity");
        set_adc(16'h1000);
        i_tca_host.wr(ADDR_CONFIG, 16'h0000);
        cyc(WAKE + CONV + 6);
        rd(ADDR_RESULT, 16'h1000);
        set_adc(16'h1400);
        cyc(CONV + 6);
        rd(ADDR_RESULT, 16'h1400);
        cyc(3);
        done("continuous");
        set_adc(16'h1800);
        i_tca_host.wr(ADDR_CONFIG, 16'h0040);
        cyc(12);
        rd(ADDR_RESULT, 16'h1800);
        set_adc(16'h1c00);
        cyc(20);
        rd(ADDR_RESULT, 16'h1800);
        cyc(20);
        rd(ADDR_RESULT, 16'h1c00);
        done("once per second");
        end_sim();
    end
endmodule : temperature_conversion_and_limit_alarms_bench
